// ### hdl/tiv_pkg.sv
// Shared constants for the triplicated input vote and its data image
package tiv_pkg;
    // Sizes of the data image
    localparam int NUM_CH = 40;       // Field input channels
    localparam int NUM_SLICE = 3;     // Redundant slices
    localparam int STATE_W = 3;       // Numeric state code width
    localparam int VOLT_W = 16;       // Field voltage word width
    localparam int NUM_THR = 4;       // Band edges between five bands
    localparam int THR_IDX_W = 2;     // Index width of a band edge
    localparam int NUM_SPARE = 16;    // Spare integer channels
    localparam int WORD_W = 16;       // Mismatch and spare word width
    localparam int NUM_MIS_WORDS = 3; // Mismatch words
    localparam int REG_W = 32;        // Register port data width
    localparam int ADDR_W = 8;        // Register port address width

    // Numeric state codes
    localparam logic [STATE_W-1:0] ST_OPEN_CIRCUIT = 3'h1;
    localparam logic [STATE_W-1:0] ST_OPEN_CONTACT = 3'h2;
    localparam logic [STATE_W-1:0] ST_INDETERMINATE = 3'h3;
    localparam logic [STATE_W-1:0] ST_CLOSED_CONTACT = 3'h4;
    localparam logic [STATE_W-1:0] ST_SHORT_CIRCUIT = 3'h5;
    localparam logic [STATE_W-1:0] ST_UNKNOWN = 3'h7;

    // Substitute voltage, minus 2048 counts of 1/512 V
    localparam logic [VOLT_W-1:0] VOLT_SUBST = 16'hF800;

    // Reset values of the band edges, in 1/512 V
    localparam logic [VOLT_W-1:0] THR0_RST = 16'h0200;
    localparam logic [VOLT_W-1:0] THR1_RST = 16'h0A00;
    localparam logic [VOLT_W-1:0] THR2_RST = 16'h1400;
    localparam logic [VOLT_W-1:0] THR3_RST = 16'h3000;

    // Register offsets of the processor end
    localparam logic [ADDR_W-1:0] REG_THR0 = 8'h00;
    localparam logic [ADDR_W-1:0] REG_THR1 = 8'h04;
    localparam logic [ADDR_W-1:0] REG_THR2 = 8'h08;
    localparam logic [ADDR_W-1:0] REG_THR3 = 8'h0C;
    localparam logic [ADDR_W-1:0] REG_POSITION = 8'h10;
    localparam logic [ADDR_W-1:0] REG_STATUS = 8'h14;

    // Position register layout and limits
    localparam int POS_W = 4;
    localparam int POS_CHASSIS_LSB = 0;
    localparam int POS_SLOT_LSB = 8;
    localparam logic [POS_W-1:0] CHASSIS_CTRL = 4'h1;
    localparam logic [POS_W-1:0] CHASSIS_MAX = 4'hF;
    localparam logic [POS_W-1:0] SLOT_MIN = 4'h1;
    localparam logic [POS_W-1:0] SLOT_MAX_CTRL = 4'h8;
    localparam logic [POS_W-1:0] SLOT_MAX_EXP = 4'hC;
    localparam logic [POS_W-1:0] CHASSIS_RST = 4'h1;
    localparam logic [POS_W-1:0] SLOT_RST = 4'h1;

    // Status register bits
    localparam int STAT_SIM = 0;
    localparam int STAT_CFG_BUSY = 1;
    localparam int STAT_POS_ERR = 2;

    // Configuration sequencer states
    typedef enum logic [1:0] {
        TIV_CFG_IDLE = 2'h1,
        TIV_CFG_SEND = 2'h2
    } tiv_cfg_state_type;
endpackage : tiv_pkg

// ### hdl/tiv_link_if.sv
`timescale 1ns/1ps
`default_nettype none
// Link between the three input slices and the voting processor
interface tiv_link_if;
    // Per-slice results
    logic [tiv_pkg::NUM_SLICE-1:0][tiv_pkg::NUM_CH-1:0][tiv_pkg::STATE_W-1:0] slice_state;
    logic [tiv_pkg::NUM_SLICE-1:0][tiv_pkg::NUM_CH-1:0][tiv_pkg::VOLT_W-1:0] slice_volt;
    logic [tiv_pkg::NUM_SLICE-1:0][tiv_pkg::NUM_CH-1:0] slice_logic;
    logic [tiv_pkg::NUM_SLICE-1:0][tiv_pkg::NUM_CH-1:0] slice_fault;
    logic [tiv_pkg::NUM_SLICE-1:0] slice_ok;
    logic [tiv_pkg::NUM_SPARE-1:0][tiv_pkg::WORD_W-1:0] spare;
    // Configuration writes from the processor
    logic cfg_wr;
    logic [tiv_pkg::THR_IDX_W-1:0] cfg_addr;
    logic [tiv_pkg::VOLT_W-1:0] cfg_data;

    // Slice end
    modport dev (
        output slice_state, slice_volt, slice_logic, slice_fault, slice_ok, spare,
        input cfg_wr, cfg_addr, cfg_data
    );
    // Processor end
    modport proc (
        input slice_state, slice_volt, slice_logic, slice_fault, slice_ok, spare,
        output cfg_wr, cfg_addr, cfg_data
    );
endinterface : tiv_link_if
`default_nettype wire

// ### hdl/tiv_slices.sv
`timescale 1ns/1ps
`default_nettype none
// Three input slices: classify each channel voltage into a band
module tiv_slices (
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic CE,
    input wire logic [tiv_pkg::NUM_SLICE-1:0][tiv_pkg::NUM_CH-1:0][tiv_pkg::VOLT_W-1:0] FIELD_VOLT,
    input wire logic [tiv_pkg::NUM_SLICE-1:0][tiv_pkg::NUM_CH-1:0] MEAS_OK,
    input wire logic [tiv_pkg::NUM_SLICE-1:0] SLICE_ALIVE,
    tiv_link_if.dev LINK
);
    // All state of the slices
    typedef struct packed {
        logic [tiv_pkg::NUM_THR-1:0][tiv_pkg::VOLT_W-1:0] thr;
        logic [tiv_pkg::NUM_SLICE-1:0][tiv_pkg::NUM_CH-1:0][tiv_pkg::STATE_W-1:0] state;
        logic [tiv_pkg::NUM_SLICE-1:0][tiv_pkg::NUM_CH-1:0][tiv_pkg::VOLT_W-1:0] volt;
        logic [tiv_pkg::NUM_SLICE-1:0][tiv_pkg::NUM_CH-1:0] logic_bit;
        logic [tiv_pkg::NUM_SLICE-1:0][tiv_pkg::NUM_CH-1:0] fault;
        logic [tiv_pkg::NUM_SLICE-1:0] ok;
        logic [tiv_pkg::NUM_SPARE-1:0][tiv_pkg::WORD_W-1:0] spare;
    } tiv_dev_state_type;

    tiv_dev_state_type s_reg; // Registered state
    tiv_dev_state_type s_next; // Next state

    // Band classification, edges are signed and ascending
    function automatic logic [tiv_pkg::STATE_W-1:0] tiv_band(
        input logic [tiv_pkg::VOLT_W-1:0] v,
        input logic [tiv_pkg::NUM_THR-1:0][tiv_pkg::VOLT_W-1:0] t
    );
        logic [tiv_pkg::STATE_W-1:0] code;
        if ($signed(v) < $signed(t[0])) begin
            code = tiv_pkg::ST_OPEN_CIRCUIT;
        end else if ($signed(v) < $signed(t[1])) begin
            code = tiv_pkg::ST_OPEN_CONTACT;
        end else if ($signed(v) < $signed(t[2])) begin
            code = tiv_pkg::ST_INDETERMINATE;
        end else if ($signed(v) < $signed(t[3])) begin
            code = tiv_pkg::ST_CLOSED_CONTACT;
        end else begin
            code = tiv_pkg::ST_SHORT_CIRCUIT;
        end
        return code;
    endfunction : tiv_band

    // Next state: take band edges, classify every channel of every slice
    always_comb begin
        logic [tiv_pkg::STATE_W-1:0] code;
        code = tiv_pkg::ST_UNKNOWN;
        s_next = s_reg;
        // Store a band edge sent by the processor
        if (LINK.cfg_wr) begin
            s_next.thr[LINK.cfg_addr] = LINK.cfg_data;
        end
        s_next.ok = SLICE_ALIVE;
        // Spare channels carry no function and stay zero
        s_next.spare = '0;
        for (int sl = 0; sl < tiv_pkg::NUM_SLICE; sl++) begin
            for (int ch = 0; ch < tiv_pkg::NUM_CH; ch++) begin
                // Band within which the voltage lies
                code = tiv_band(FIELD_VOLT[sl][ch], s_reg.thr);
                // A slice that cannot measure reports unknown
                if (!MEAS_OK[sl][ch]) begin
                    code = tiv_pkg::ST_UNKNOWN;
                end
                s_next.state[sl][ch] = code;
                // Signed 1/512 V word passed on unchanged over its full span
                s_next.volt[sl][ch] = FIELD_VOLT[sl][ch];
                // Closed contact reads one, anything else zero
                s_next.logic_bit[sl][ch] = (code == tiv_pkg::ST_CLOSED_CONTACT);
                // Line fault for open circuit, indeterminate or short
                s_next.fault[sl][ch] = (code == tiv_pkg::ST_OPEN_CIRCUIT)
                    || (code == tiv_pkg::ST_INDETERMINATE)
                    || (code == tiv_pkg::ST_SHORT_CIRCUIT);
            end
        end
    end

    // State register with clock enable and synchronous reset
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            s_reg <= '0;
            s_reg.thr <= {tiv_pkg::THR3_RST, tiv_pkg::THR2_RST,
                          tiv_pkg::THR1_RST, tiv_pkg::THR0_RST};
            s_reg.state <= {(tiv_pkg::NUM_SLICE * tiv_pkg::NUM_CH){tiv_pkg::ST_UNKNOWN}};
        end else if (CE) begin
            s_reg <= s_next;
        end
    end

    // Link outputs straight from the register
    assign LINK.slice_state = s_reg.state;
    assign LINK.slice_volt = s_reg.volt;
    assign LINK.slice_logic = s_reg.logic_bit;
    assign LINK.slice_fault = s_reg.fault;
    assign LINK.slice_ok = s_reg.ok;
    assign LINK.spare = s_reg.spare;
endmodule : tiv_slices
`default_nettype wire

// ### hdl/tiv_processor.sv
// Decided for this implementation: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module tiv_processor (
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic CE,
    input wire logic MODULE_PRESENT,
    input wire logic APP_LOADED,
    input wire logic CHANGEOVER,
    input wire logic [tiv_pkg::ADDR_W-1:0] REG_ADDR,
    input wire logic [tiv_pkg::REG_W-1:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [tiv_pkg::REG_W-1:0] REG_RDATA,
    output logic [tiv_pkg::NUM_CH-1:0] LOGICAL_STATE_BOARD,
    output logic [tiv_pkg::NUM_CH-1:0][tiv_pkg::STATE_W-1:0] STATE_BOARD,
    output logic [tiv_pkg::NUM_CH-1:0][tiv_pkg::VOLT_W-1:0] FIELD_VOLTAGE_BOARD,
    output logic [tiv_pkg::NUM_CH-1:0] LINE_FAULT_BOARD,
    output logic [tiv_pkg::NUM_MIS_WORDS-1:0][tiv_pkg::WORD_W-1:0] SLICE_MISMATCH_BOARD,
    output logic [tiv_pkg::NUM_SPARE-1:0][tiv_pkg::WORD_W-1:0] SPARE_BOARD,
    tiv_link_if.proc LINK
);
    // All state of the processor end
    typedef struct packed {
        logic [tiv_pkg::NUM_THR-1:0][tiv_pkg::VOLT_W-1:0] thr;
        logic [tiv_pkg::POS_W-1:0] chassis;
        logic [tiv_pkg::POS_W-1:0] slot;
        logic pos_err;
        tiv_pkg::tiv_cfg_state_type cfg_state;
        logic [tiv_pkg::THR_IDX_W-1:0] cfg_idx;
        logic cfg_pend;
        logic cfg_wr;
        logic [tiv_pkg::THR_IDX_W-1:0] cfg_addr;
        logic [tiv_pkg::VOLT_W-1:0] cfg_data;
        logic [tiv_pkg::REG_W-1:0] rdata;
        logic sim;
        logic [tiv_pkg::NUM_CH-1:0] logic_b;
        logic [tiv_pkg::NUM_CH-1:0][tiv_pkg::STATE_W-1:0] state_b;
        logic [tiv_pkg::NUM_CH-1:0][tiv_pkg::VOLT_W-1:0] volt_b;
        logic [tiv_pkg::NUM_CH-1:0] fault_b;
        logic [tiv_pkg::NUM_MIS_WORDS-1:0][tiv_pkg::WORD_W-1:0] mis_b;
        logic [tiv_pkg::NUM_SPARE-1:0][tiv_pkg::WORD_W-1:0] spare_b;
    } tiv_proc_state_type;

    tiv_proc_state_type s_reg; // Registered state
    tiv_proc_state_type s_next; // Next state

    // Median of three signed words
    function automatic logic [tiv_pkg::VOLT_W-1:0] tiv_median(
        input logic signed [tiv_pkg::VOLT_W-1:0] a,
        input logic signed [tiv_pkg::VOLT_W-1:0] b,
        input logic signed [tiv_pkg::VOLT_W-1:0] c
    );
        logic signed [tiv_pkg::VOLT_W-1:0] lo;
        logic signed [tiv_pkg::VOLT_W-1:0] hi;
        logic signed [tiv_pkg::VOLT_W-1:0] mid;
        lo = (a < b) ? a : b;
        hi = (a < b) ? b : a;
        mid = (hi < c) ? hi : c;
        return (lo > mid) ? lo : mid;
    endfunction : tiv_median

    // Majority of three bits
    function automatic logic tiv_maj(input logic a, input logic b, input logic c);
        return (a & b) | (a & c) | (b & c);
    endfunction : tiv_maj

    // Next state: registers, configuration sequencer and vote
    always_comb begin
        logic [tiv_pkg::STATE_W-1:0] sa;
        logic [tiv_pkg::STATE_W-1:0] sb;
        logic [tiv_pkg::STATE_W-1:0] sc;
        logic [tiv_pkg::STATE_W-1:0] voted;
        logic no_major;
        logic [1:0] bad_cnt;
        logic [1:0] alive_cnt;
        logic chan_bad;
        logic [tiv_pkg::POS_W-1:0] new_ch;
        logic [tiv_pkg::POS_W-1:0] new_sl;
        logic [tiv_pkg::POS_W-1:0] slot_max;
        sa = '0;
        sb = '0;
        sc = '0;
        voted = '0;
        no_major = 1'b0;
        bad_cnt = '0;
        chan_bad = 1'b0;
        new_ch = REG_WDATA[tiv_pkg::POS_CHASSIS_LSB +: tiv_pkg::POS_W];
        new_sl = REG_WDATA[tiv_pkg::POS_SLOT_LSB +: tiv_pkg::POS_W];
        slot_max = (new_ch == tiv_pkg::CHASSIS_CTRL) ? tiv_pkg::SLOT_MAX_CTRL
                                                     : tiv_pkg::SLOT_MAX_EXP;
        alive_cnt = 2'({1'b0, LINK.slice_ok[0]} + {1'b0, LINK.slice_ok[1]}
                       + {1'b0, LINK.slice_ok[2]});
        s_next = s_reg;
        s_next.rdata = '0;

        // Register writes
        if (REG_WR) begin
            unique case (REG_ADDR)
                tiv_pkg::REG_THR0: s_next.thr[0] = REG_WDATA[tiv_pkg::VOLT_W-1:0];
                tiv_pkg::REG_THR1: s_next.thr[1] = REG_WDATA[tiv_pkg::VOLT_W-1:0];
                tiv_pkg::REG_THR2: s_next.thr[2] = REG_WDATA[tiv_pkg::VOLT_W-1:0];
                tiv_pkg::REG_THR3: s_next.thr[3] = REG_WDATA[tiv_pkg::VOLT_W-1:0];
                tiv_pkg::REG_POSITION: begin
                    // Accept only a legal chassis and slot pair
                    if (new_ch >= tiv_pkg::CHASSIS_CTRL && new_ch <= tiv_pkg::CHASSIS_MAX
                        && new_sl >= tiv_pkg::SLOT_MIN && new_sl <= slot_max) begin
                        s_next.chassis = new_ch;
                        s_next.slot = new_sl;
                    end else begin
                        s_next.pos_err = 1'b1;
                    end
                end
                tiv_pkg::REG_STATUS: begin
                    // Writing one clears the position error
                    if (REG_WDATA[tiv_pkg::STAT_POS_ERR]) begin
                        s_next.pos_err = 1'b0;
                    end
                end
                default: ; // Unmapped writes are dropped
            endcase
        end

        // Register reads, data valid in the next cycle only
        if (REG_RD) begin
            unique case (REG_ADDR)
                tiv_pkg::REG_THR0: s_next.rdata = {16'h0000, s_reg.thr[0]};
                tiv_pkg::REG_THR1: s_next.rdata = {16'h0000, s_reg.thr[1]};
                tiv_pkg::REG_THR2: s_next.rdata = {16'h0000, s_reg.thr[2]};
                tiv_pkg::REG_THR3: s_next.rdata = {16'h0000, s_reg.thr[3]};
                tiv_pkg::REG_POSITION: begin
                    s_next.rdata[tiv_pkg::POS_CHASSIS_LSB +: tiv_pkg::POS_W] = s_reg.chassis;
                    s_next.rdata[tiv_pkg::POS_SLOT_LSB +: tiv_pkg::POS_W] = s_reg.slot;
                end
                tiv_pkg::REG_STATUS: begin
                    s_next.rdata[tiv_pkg::STAT_SIM] = s_reg.sim;
                    s_next.rdata[tiv_pkg::STAT_CFG_BUSY] =
                        (s_reg.cfg_state == tiv_pkg::TIV_CFG_SEND) | s_reg.cfg_pend;
                    s_next.rdata[tiv_pkg::STAT_POS_ERR] = s_reg.pos_err;
                end
                default: s_next.rdata = '0; // Unmapped reads return zero
            endcase
        end

        // Configuration sequencer, one band edge per cycle
        s_next.cfg_wr = 1'b0;
        if (APP_LOADED || CHANGEOVER) begin
            s_next.cfg_pend = 1'b1;
        end
        unique case (s_reg.cfg_state)
            tiv_pkg::TIV_CFG_IDLE: begin
                // Start a download when one is pending
                if (s_reg.cfg_pend) begin
                    s_next.cfg_state = tiv_pkg::TIV_CFG_SEND;
                    s_next.cfg_idx = '0;
                    s_next.cfg_pend = APP_LOADED | CHANGEOVER;
                end
            end
            tiv_pkg::TIV_CFG_SEND: begin
                // Drive one write per edge until the last edge is sent
                s_next.cfg_wr = 1'b1;
                s_next.cfg_addr = s_reg.cfg_idx;
                s_next.cfg_data = s_reg.thr[s_reg.cfg_idx];
                s_next.cfg_idx = 2'(s_reg.cfg_idx + 2'h1);
                if (s_reg.cfg_idx == 2'(tiv_pkg::NUM_THR - 1)) begin
                    s_next.cfg_state = tiv_pkg::TIV_CFG_IDLE;
                end
            end
            default: s_next.cfg_state = tiv_pkg::TIV_CFG_IDLE; // Illegal code recovers
        endcase

        // Module absent or fewer than two slices reachable
        s_next.sim = !MODULE_PRESENT || (alive_cnt < 2'h2);

        // Per-channel vote
        s_next.mis_b = '0;
        for (int ch = 0; ch < tiv_pkg::NUM_CH; ch++) begin
            sa = LINK.slice_state[0][ch];
            sb = LINK.slice_state[1][ch];
            sc = LINK.slice_state[2][ch];
            no_major = 1'b0;
            // Majority of the three state codes
            if (sa == sb || sa == sc) begin
                voted = sa;
            end else if (sb == sc) begin
                voted = sb;
            end else begin
                voted = tiv_pkg::ST_UNKNOWN;
                no_major = 1'b1;
            end
            bad_cnt = 2'({1'b0, sa == tiv_pkg::ST_UNKNOWN} + {1'b0, sb == tiv_pkg::ST_UNKNOWN}
                         + {1'b0, sc == tiv_pkg::ST_UNKNOWN});
            chan_bad = s_next.sim || no_major || (bad_cnt >= 2'h2)
                       || (voted == tiv_pkg::ST_UNKNOWN);
            s_next.state_b[ch] = chan_bad ? tiv_pkg::ST_UNKNOWN : voted;
            // Median voltage, substitute on fault or simulation
            s_next.volt_b[ch] = chan_bad ? tiv_pkg::VOLT_SUBST
                : tiv_median(LINK.slice_volt[0][ch], LINK.slice_volt[1][ch],
                             LINK.slice_volt[2][ch]);
            // Majority logical state
            s_next.logic_b[ch] = tiv_maj(LINK.slice_logic[0][ch], LINK.slice_logic[1][ch],
                                         LINK.slice_logic[2][ch]);
            // Majority line fault, forced true on fault or simulation
            s_next.fault_b[ch] = chan_bad | tiv_maj(LINK.slice_fault[0][ch],
                LINK.slice_fault[1][ch], LINK.slice_fault[2][ch]);
            // Mismatch when any slice differs, lowest channel at bit 0
            s_next.mis_b[ch / tiv_pkg::WORD_W][ch % tiv_pkg::WORD_W] =
                !(sa == sb && sb == sc);
        end
        // Spare board passed through, held zero by the slices
        s_next.spare_b = LINK.spare;
    end

    // State register with clock enable and synchronous reset
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            s_reg <= '0;
            s_reg.thr <= {tiv_pkg::THR3_RST, tiv_pkg::THR2_RST,
                          tiv_pkg::THR1_RST, tiv_pkg::THR0_RST};
            s_reg.chassis <= tiv_pkg::CHASSIS_RST;
            s_reg.slot <= tiv_pkg::SLOT_RST;
            s_reg.cfg_state <= tiv_pkg::TIV_CFG_IDLE;
            s_reg.sim <= 1'b1;
            s_reg.state_b <= {tiv_pkg::NUM_CH{tiv_pkg::ST_UNKNOWN}};
            s_reg.volt_b <= {tiv_pkg::NUM_CH{tiv_pkg::VOLT_SUBST}};
            s_reg.fault_b <= '1;
        end else if (CE) begin
            s_reg <= s_next;
        end
    end

    // Outputs straight from the register
    assign REG_RDATA = s_reg.rdata;
    assign LOGICAL_STATE_BOARD = s_reg.logic_b;
    assign STATE_BOARD = s_reg.state_b;
    assign FIELD_VOLTAGE_BOARD = s_reg.volt_b;
    assign LINE_FAULT_BOARD = s_reg.fault_b;
    assign SLICE_MISMATCH_BOARD = s_reg.mis_b;
    assign SPARE_BOARD = s_reg.spare_b;
    assign LINK.cfg_wr = s_reg.cfg_wr;
    assign LINK.cfg_addr = s_reg.cfg_addr;
    assign LINK.cfg_data = s_reg.cfg_data;
endmodule : tiv_processor
`default_nettype wire

// ### tb/tiv_link_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// Watches the link between the slices and the processor
module tiv_link_assertions (
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic [2:0][39:0][2:0] slice_state,
    input wire logic [2:0][39:0] slice_logic,
    input wire logic [2:0][39:0] slice_fault,
    input wire logic [2:0] slice_ok,
    input wire logic [15:0][15:0] spare,
    input wire logic cfg_wr,
    input wire logic [1:0] cfg_addr
);
    logic [2:0][39:0] want_logic, want_fault, legal; // Flags each code demands
    // Derive the expected flags from every slice code
    always_comb begin
        for (int s = 0; s < 3; s++) begin
            for (int c = 0; c < 40; c++) begin
                want_logic[s][c] = slice_state[s][c] == 3'h4;
                want_fault[s][c] = slice_state[s][c] inside {3'h1, 3'h3, 3'h5};
                legal[s][c] = slice_state[s][c] inside {[3'h1:3'h5], 3'h7};
            end
        end
    end
    default clocking dc @(posedge REF_CLK); endclocking
    default disable iff (RST);
    closed_logic_a:
        assert property (slice_logic == want_logic) else $error("Logic flag wrong");
    fault_band_a:
        assert property (slice_fault == want_fault) else $error("Line fault flag wrong");
    code_legal_a:
        assert property (&legal) else $error("Illegal state code");
    spare_zero_a:
        assert property (spare == '0) else $error("Spare word not zero");
    cfg_burst_a:
        assert property ($rose(cfg_wr) |-> cfg_wr[*4]) else $error("Config burst short");
    cfg_order_a:
        assert property ($rose(cfg_wr) |-> cfg_addr == 2'h0 ##1 cfg_addr == 2'h1
            ##1 cfg_addr == 2'h2 ##1 cfg_addr == 2'h3) else $error("Config order wrong");
    cfg_end_a:
        assert property ($fell(cfg_wr) |-> $past(cfg_addr) == 2'h3) else $error("Burst cut");
    reset_unknown_a:
        assert property ($fell(RST) |-> slice_ok == 3'h0 && slice_state == {120{3'h7}})
            else $error("Reset state wrong");
endmodule : tiv_link_assertions
`default_nettype wire

// ### tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_total++; \
    $display("Error at %0t: got %h expected %h", $time, (g), (e)); end end
// Both ends joined by the link, compared with an integer model
module tb_top;
    logic ref_clk = 1'b0, rst = 1'b1, present = 1'b0, app_ld = 1'b0, chg = 1'b0;
    logic reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, reg_rdata;
    logic [2:0][39:0][15:0] field_volt = '0; // Slice voltages
    logic [2:0][39:0] meas_ok = '1;
    logic [2:0] slice_alive = 3'h7;
    logic [39:0] logical_b, line_b;
    logic [39:0][2:0] state_b;
    logic [39:0][15:0] volt_b;
    logic [2:0][15:0] mis_b;
    logic [15:0][15:0] spare_b;
    int err_total = 0, n_checks = 0;
    int thr[4] = '{16'h0200, 16'h0A00, 16'h1400, 16'h3000}; // Band edges in the model
    tiv_link_if i_tiv_link_if ();
    tiv_slices i_tiv_slices (.REF_CLK(ref_clk), .RST(rst), .CE(1'b1), .FIELD_VOLT(field_volt),
        .MEAS_OK(meas_ok), .SLICE_ALIVE(slice_alive), .LINK(i_tiv_link_if.dev));
    tiv_processor i_tiv_processor (.REF_CLK(ref_clk), .RST(rst), .CE(1'b1),
        .MODULE_PRESENT(present), .APP_LOADED(app_ld), .CHANGEOVER(chg), .REG_ADDR(reg_addr),
        .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
        .LOGICAL_STATE_BOARD(logical_b), .STATE_BOARD(state_b), .FIELD_VOLTAGE_BOARD(volt_b),
        .LINE_FAULT_BOARD(line_b), .SLICE_MISMATCH_BOARD(mis_b), .SPARE_BOARD(spare_b),
        .LINK(i_tiv_link_if.proc));
    tiv_link_assertions i_tiv_link_assertions (.REF_CLK(ref_clk), .RST(rst),
        .slice_state(i_tiv_link_if.slice_state), .slice_logic(i_tiv_link_if.slice_logic),
        .slice_fault(i_tiv_link_if.slice_fault), .slice_ok(i_tiv_link_if.slice_ok),
        .spare(i_tiv_link_if.spare), .cfg_wr(i_tiv_link_if.cfg_wr),
        .cfg_addr(i_tiv_link_if.cfg_addr));
    // Free-running clock
    always #10 ref_clk = ~ref_clk;
    // One register cycle; read data taken in the cycle after the strobe
    task automatic rw(input logic wr, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q);
        @(posedge ref_clk);
        reg_wr <= wr;
        reg_rd <= !wr;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        #1 q = reg_rdata;
    endtask : rw
    // Band of one slice reading
    function automatic int band(int v, logic ok);
        if (!ok) return 7;
        for (int i = 0; i < 4; i++) if (v < thr[i]) return i + 1;
        return 5;
    endfunction : band
    // Compare every board with the model
    task automatic check_all();
        int k[3], v[3], m, med;
        logic sim, bad;
        sim = !present || !(slice_alive inside {3'h3, 3'h5, 3'h6, 3'h7});
        for (int c = 0; c < 40; c++) begin
            for (int s = 0; s < 3; s++) begin
                v[s] = $signed(field_volt[s][c]);
                k[s] = band(v[s], meas_ok[s][c]);
            end
            m = (k[0] == k[1] || k[0] == k[2]) ? k[0] : (k[1] == k[2]) ? k[1] : 7;
            med = (v[0] < v[1]) ? v[0] : v[1];
            med = (med > ((v[0] < v[1]) ? v[1] : v[0]) || med > v[2]) ? med : v[2];
            med = v[0] + v[1] + v[2] - (v[0] < v[1] ? (v[0] < v[2] ? v[0] : v[2]) :
                (v[1] < v[2] ? v[1] : v[2])) - (v[0] > v[1] ? (v[0] > v[2] ? v[0] : v[2]) :
                (v[1] > v[2] ? v[1] : v[2]));
            bad = sim || m == 7;
            `CHK(state_b[c], bad ? 3'h7 : 3'(m))
            `CHK(volt_b[c], bad ? 16'hF800 : 16'(med))
            `CHK(line_b[c], bad || m inside {1, 3, 5})
            if (!sim) begin
                `CHK(logical_b[c], (k[0] == 4) + (k[1] == 4) + (k[2] == 4) > 1)
                `CHK(mis_b[c / 16][c % 16], !(k[0] == k[1] && k[1] == k[2]))
            end
        end
        `CHK(mis_b[2][15:8], 8'h00)
        `CHK(spare_b, '0)
    endtask : check_all
    // Print counts and verdict, then stop
    task automatic complete_run();
        $display("Checks %0d, errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : complete_run
    // Watchdog against a hang
    initial begin
        repeat (20000) @(posedge ref_clk);
        err_total++;
        complete_run();
    end
    // Main sequence
    initial begin
        logic [31:0] q;
        int b;
        q = $urandom(32'hCEF85984);
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        rw(1'b0, tiv_pkg::REG_STATUS, 32'h0, q);
        `CHK(q[tiv_pkg::STAT_SIM], 1'b1)
        rw(1'b0, 8'h3C, 32'h0, q);
        `CHK(q, 32'h0)
        // New band edges, sent by a download and then a changeover
        for (int i = 0; i < 4; i++) begin
            thr[i] = 16'h0400 + i * 16'h0C00;
            rw(1'b1, 8'(i * 4), 32'(thr[i]), q);
            rw(1'b0, 8'(i * 4), 32'h0, q);
            `CHK(q, 32'(thr[i]))
        end
        app_ld <= 1'b1;
        @(posedge ref_clk);
        app_ld <= 1'b0;
        chg <= 1'b1;
        @(posedge ref_clk);
        chg <= 1'b0;
        // Send under way, second request still pending
        rw(1'b0, tiv_pkg::REG_STATUS, 32'h0, q);
        `CHK(q[tiv_pkg::STAT_CFG_BUSY], 1'b1)
        repeat (16) @(posedge ref_clk);
        rw(1'b1, tiv_pkg::REG_POSITION, 32'h0000_0901, q);
        rw(1'b0, tiv_pkg::REG_STATUS, 32'h0, q);
        `CHK(q[tiv_pkg::STAT_POS_ERR], 1'b1)
        rw(1'b1, tiv_pkg::REG_POSITION, 32'h0000_0C02, q);
        rw(1'b0, tiv_pkg::REG_POSITION, 32'h0, q);
        `CHK(q, 32'h0000_0C02)
        // Random readings, faults and simulated states
        for (int n = 0; n < 80; n++) begin
            // New readings launched on a rising edge
            @(posedge ref_clk);
            for (int c = 0; c < 40; c++) begin
                b = int'($urandom_range(16'h3000)) - 16'h0600;
                for (int s = 0; s < 3; s++) begin
                    field_volt[s][c] <= 16'(($urandom_range(3) == 0) ? b + $urandom_range(16'h1000) - 16'h0800 : b);
                    meas_ok[s][c] <= ($urandom_range(15) != 0);
                end
            end
            slice_alive <= ($urandom_range(7) == 0) ? 3'(1 << $urandom_range(2)) : 3'h7;
            present <= ($urandom_range(9) != 0);
            repeat (3) @(posedge ref_clk);
            #1 check_all();
        end
        complete_run();
    end
endmodule : tb_top
`default_nettype wire
